//--- src/uarb_pkg.sv
// constants, carriers and functions for the serial address recognition block
//
// Overview of operation
// - mode 2 baud: peripheral clock over 16 or 32
// - peripheral clock: oscillator halved, or undivided
// - ninth bit set means address, clear means data
// - filtering on: data frames dropped, no done or ninth-bit flags
// - matching address frame sets ninth-bit and done flags
// - filtering off: every frame accepted normally
// - mode 1: stop bit stands for ninth bit
// - mode 0: filtering and recognition never active
// - given match compares only where mask is one
// - broadcast is address OR mask, zeros ignored
// - either given or broadcast match is enough
// - full mask compares all eight bits
// - address and mask bytes reset to zero
// - receive and transmit done ORed into one request
// - done flags cleared only by software
// - request needs serial and global enables both
// - done flag set on ninth or stop bit
// - framing detection moves done flag to stop bit outside mode 0
// - framing error sticky until software or reset
package uarb_pkg;

    // serial port modes
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE1 = 2'h1;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [1:0] MODE3 = 2'h3;

    // reset values
    localparam logic [7:0] ADDR_RESET     = 8'h00;
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [4:0] BAUD_CNT_RESET = 5'h00;

    // baud divider reload: counts of peripheral ticks minus one
    localparam logic [4:0] BAUD_DIV16_LAST = 5'h0F;
    localparam logic [4:0] BAUD_DIV32_LAST = 5'h1F;

    // receive buffer shape
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 8;

    // frame handed over by the shift logic at its last data bit
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
    } uarb_frame_s;

    // given match: only mask ones are compared
    function automatic logic uarb_given_match(input logic [7:0] rx, input logic [7:0] addr,
                                              input logic [7:0] mask);
        uarb_given_match = (((rx ^ addr) & mask) == 8'h00);
    endfunction

    // broadcast match: ones of address OR mask must be ones in the frame
    function automatic logic uarb_addr_match(input logic [7:0] rx, input logic [7:0] addr,
                                             input logic [7:0] mask);
        logic [7:0] bcast;
        bcast = addr | mask;
        uarb_addr_match = uarb_given_match(rx, addr, mask) || ((rx & bcast) == bcast);
    endfunction

endpackage

//--- src/uarb_addr_recog.sv
// receive buffer fifo and the address recognition, baud and flag logic
`timescale 1ns/1ps
`default_nettype none

module uarb_fifo
    import uarb_pkg::*;
#(
    parameter int W     = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } uarb_fifo_state_s;

    uarb_fifo_state_s s_q;
    uarb_fifo_state_s s_d;
    logic             push;
    logic             pop;

    // honest flags straight from the count
    assign in_ready  = (s_q.cnt != CW'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers wrap naturally, so depth must be a power of two
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module uarb_addr_recog
    import uarb_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // configuration
    input  wire logic [1:0]  mode,
    input  wire logic        multiproc_enable,
    input  wire logic        fe_detect_enable,
    input  wire logic        baud_double_sel,
    input  wire logic        double_clock_mode,
    input  wire logic        serial_irq_enable,
    input  wire logic        global_irq_enable,
    // address and mask byte writes
    input  wire logic        addr_wr,
    input  wire logic [7:0]  addr_wdata,
    input  wire logic        mask_wr,
    input  wire logic [7:0]  mask_wdata,
    // frame shift logic side
    input  wire logic        bit_evt,
    input  wire uarb_frame_s bit_frame,
    input  wire logic        stop_evt,
    input  wire logic        stop_ok,
    output logic             frm_ready,
    input  wire logic        tx_done_evt,
    // software clears
    input  wire logic        rx_done_clr,
    input  wire logic        tx_done_clr,
    input  wire logic        fe_clr,
    // status and timing
    output logic             rx_done_flag,
    output logic             tx_done_flag,
    output logic             rx_ninth_bit,
    output logic             framing_error_flag,
    output logic             serial_irq,
    output logic             periph_tick,
    output logic             baud_tick,
    output logic [7:0]       slave_individual_addr,
    output logic [7:0]       slave_addr_mask,
    // received byte stream
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic [7:0]       rx_data
);
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] mask;
        logic       ptick;
        logic [4:0] bcnt;
        logic       btick;
        logic       pend;
        logic [7:0] pdata;
        logic       pninth;
        logic       ri;
        logic       ti;
        logic       rb8;
        logic       fe;
        logic       irq;
    } uarb_state_s;

    localparam uarb_state_s STATE_RESET = '{
        addr:   ADDR_RESET,
        mask:   MASK_RESET,
        bcnt:   BAUD_CNT_RESET,
        default: '0
    };

    uarb_state_s s_q;
    uarb_state_s s_d;
    logic        mp_active;
    logic        use_stop;
    logic        set_evt;
    logic [7:0]  f_data;
    logic        f_ninth;
    logic        addr_bit;
    logic        match;
    logic        accept;
    logic        rx_set;
    logic        fe_set;

    // frame decision terms; mode 0 masks the enable bit entirely
    assign mp_active = multiproc_enable && (mode != MODE0);
    assign use_stop  = (mode != MODE0) && ((mode == MODE1) || fe_detect_enable);
    assign set_evt   = use_stop ? (stop_evt && s_q.pend) : bit_evt;
    assign f_data    = use_stop ? s_q.pdata : bit_frame.data;
    assign f_ninth   = use_stop ? s_q.pninth : bit_frame.ninth;
    assign addr_bit  = (mode == MODE1) ? stop_ok : f_ninth;
    assign match     = uarb_addr_match(f_data, s_q.addr, s_q.mask);
    assign accept    = !mp_active || (addr_bit && match);
    assign rx_set    = set_evt && accept;
    assign fe_set    = stop_evt && fe_detect_enable && !stop_ok;

    always_comb begin
        s_d = s_q;
        // peripheral tick: every other cycle, or every cycle when doubled
        s_d.ptick = double_clock_mode ? 1'b1 : !s_q.ptick;
        // baud divider reloads only at a tick so the rate never glitches short
        s_d.btick = 1'b0;
        if (s_q.ptick) begin
            if (s_q.bcnt == 5'h00) begin
                s_d.bcnt  = baud_double_sel ? BAUD_DIV16_LAST : BAUD_DIV32_LAST;
                s_d.btick = (mode == MODE2);
            end else begin
                s_d.bcnt = s_q.bcnt - 5'h01;
            end
        end
        // address and mask bytes
        if (addr_wr) begin
            s_d.addr = addr_wdata;
        end
        if (mask_wr) begin
            s_d.mask = mask_wdata;
        end
        // hold the frame until its stop bit when the decision waits for it
        if (bit_evt) begin
            s_d.pend   = 1'b1;
            s_d.pdata  = bit_frame.data;
            s_d.pninth = bit_frame.ninth;
        end else if (stop_evt) begin
            s_d.pend = 1'b0;
        end
        // ninth-bit flag follows only accepted frames
        if (rx_set && (mode != MODE0)) begin
            s_d.rb8 = addr_bit;
        end
        // set wins over a clear in the same cycle; hardware never clears
        s_d.ri  = (s_q.ri & !rx_done_clr) | rx_set;
        s_d.ti  = (s_q.ti & !tx_done_clr) | tx_done_evt;
        s_d.fe  = (s_q.fe & !fe_clr) | fe_set;
        s_d.irq = (s_d.ri | s_d.ti) & serial_irq_enable & global_irq_enable;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign rx_done_flag          = s_q.ri;
    assign tx_done_flag          = s_q.ti;
    assign rx_ninth_bit          = s_q.rb8;
    assign framing_error_flag    = s_q.fe;
    assign serial_irq            = s_q.irq;
    assign periph_tick           = s_q.ptick;
    assign baud_tick             = s_q.btick;
    assign slave_individual_addr = s_q.addr;
    assign slave_addr_mask       = s_q.mask;

    // receive buffer; a full buffer drops the byte, so frm_ready throttles the shifter
    uarb_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (rx_set),
        .in_ready  (frm_ready),
        .in_data   (f_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    a_irq_combine: assert property (@(posedge clock) disable iff (!rst_n)
        serial_irq == ((rx_done_flag || tx_done_flag) && $past(serial_irq_enable && global_irq_enable)))
        else $error("serial request does not follow flags and enables");

    a_rx_hold: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done_flag && !rx_done_clr |=> rx_done_flag)
        else $error("receive done flag cleared by hardware");

    a_tx_hold: assert property (@(posedge clock) disable iff (!rst_n)
        tx_done_flag && !tx_done_clr |=> tx_done_flag)
        else $error("transmit done flag cleared by hardware");

    a_data_discard: assert property (@(posedge clock) disable iff (!rst_n)
        set_evt && multiproc_enable && mode[1] && !f_ninth && !rx_done_flag |=> !rx_done_flag)
        else $error("data frame raised done flag while filtering");

    a_addr_accept: assert property (@(posedge clock) disable iff (!rst_n)
        set_evt && multiproc_enable && mode[1] && f_ninth && match |=> rx_done_flag && rx_ninth_bit)
        else $error("matching address frame not flagged");

    a_given_mask: assert property (@(posedge clock) disable iff (!rst_n)
        set_evt && multiproc_enable && mode[1] && f_ninth
        && (((f_data ^ slave_individual_addr) & slave_addr_mask) == 8'h00) |=> rx_done_flag)
        else $error("given address match missed");

    a_mode1_stop: assert property (@(posedge clock) disable iff (!rst_n)
        set_evt && multiproc_enable && (mode == MODE1) && !stop_ok && !rx_done_flag |=> !rx_done_flag)
        else $error("mode 1 frame without valid stop accepted");

    a_mode0_free: assert property (@(posedge clock) disable iff (!rst_n)
        bit_evt && (mode == MODE0) |=> rx_done_flag)
        else $error("mode 0 frame filtered");

    a_fe_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        framing_error_flag && !fe_clr |=> framing_error_flag)
        else $error("framing error flag lost");

    a_baud_gap: assert property (@(posedge clock) disable iff (!rst_n)
        baud_tick |=> !baud_tick [*8] ##1 !baud_tick [*7])
        else $error("baud ticks closer than sixteen cycles");

    a_baud_mode: assert property (@(posedge clock) disable iff (!rst_n)
        baud_tick |-> $past(mode) == MODE2)
        else $error("baud tick outside mode 2");

    a_tx_set: assert property (@(posedge clock) disable iff (!rst_n)
        tx_done_evt |=> tx_done_flag)
        else $error("transmit done event lost");

    a_fe_set: assert property (@(posedge clock) disable iff (!rst_n)
        stop_evt && fe_detect_enable && !stop_ok |=> framing_error_flag)
        else $error("broken stop bit not flagged");

    a_mode0_ninth: assert property (@(posedge clock) disable iff (!rst_n)
        mode == MODE0 |=> $stable(rx_ninth_bit))
        else $error("ninth flag changed in mode 0");

    a_stop_wait: assert property (@(posedge clock) disable iff (!rst_n)
        bit_evt && !stop_evt && fe_detect_enable && mode[1] && !rx_done_flag |=> !rx_done_flag)
        else $error("done flag raised before stop bit");

    a_push_accept: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rx_valid) |-> $past(rx_set))
        else $error("byte entered buffer without acceptance");

endmodule

`default_nettype wire

//--- tb/uarb_master_model.sv
// frame shifter and line master model handing received frames to the block
`timescale 1ns/1ps
`default_nettype none

module uarb_master_model
    import uarb_pkg::*;
(
    // clock
    input  wire logic   clock,
    // frame handover
    input  wire logic   frm_ready,
    output uarb_frame_s bit_frame,
    output logic        bit_evt,
    output logic        stop_evt,
    output logic        stop_ok
);
    // idle lines start at zero, then show inverted junk after each frame so a stale frame never looks valid
    initial begin
        bit_frame = '0;
        bit_evt   = 1'b0;
        stop_evt  = 1'b0;
        stop_ok   = 1'b0;
    end

    // last data bit sampled; holds off while the buffer has no room
    task automatic send_bits(input uarb_frame_s f, output logic stuck);
        int n;
        n = 0;
        while (frm_ready !== 1'b1 && n < 64) begin
            @(posedge clock);
            n++;
        end
        stuck = (frm_ready !== 1'b1); // caller ends the run on a stall
        @(posedge clock);
        bit_evt   <= 1'b1;
        bit_frame <= f;
        @(posedge clock);
        bit_evt   <= 1'b0;
        bit_frame <= ~f;
        repeat (3) @(posedge clock);
    endtask

    // stop bit sampled, valid or broken as the caller asks
    task automatic send_stop(input logic ok);
        @(posedge clock);
        stop_evt <= 1'b1;
        stop_ok  <= ok;
        @(posedge clock);
        stop_evt <= 1'b0;
        stop_ok  <= ~ok;
    endtask
endmodule

`default_nettype wire

//--- tb/uarb_addr_recog_tb.sv
// self-checking bench for address recognition, flags, baud and receive buffer
`timescale 1ns/1ps
`default_nettype none

module uarb_addr_recog_tb;
    import uarb_pkg::*;

    logic        clock, rst_n, multiproc_enable, fe_detect_enable, baud_double_sel, double_clock_mode;
    logic        serial_irq_enable, global_irq_enable, addr_wr, mask_wr, tx_done_evt, rx_ready;
    logic        rx_done_clr, tx_done_clr, fe_clr, bit_evt, stop_evt, stop_ok, frm_ready;
    logic        rx_done_flag, tx_done_flag, rx_ninth_bit, framing_error_flag, serial_irq;
    logic        periph_tick, baud_tick, rx_valid;
    logic [1:0]  mode;
    logic [7:0]  addr_wdata, mask_wdata, slave_individual_addr, slave_addr_mask, rx_data;
    uarb_frame_s bit_frame;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [7:0]  q[$];

    uarb_addr_recog uut (.clock, .rst_n, .mode, .multiproc_enable, .fe_detect_enable, .baud_double_sel,
        .double_clock_mode, .serial_irq_enable, .global_irq_enable, .addr_wr, .addr_wdata, .mask_wr,
        .mask_wdata, .bit_evt, .bit_frame, .stop_evt, .stop_ok, .frm_ready, .tx_done_evt, .rx_done_clr,
        .tx_done_clr, .fe_clr, .rx_done_flag, .tx_done_flag, .rx_ninth_bit, .framing_error_flag,
        .serial_irq, .periph_tick, .baud_tick, .slave_individual_addr, .slave_addr_mask, .rx_valid,
        .rx_ready, .rx_data);
    uarb_master_model m (.clock, .frm_ready, .bit_frame, .bit_evt, .stop_evt, .stop_ok);

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // software clear pulses {rx, tx, framing}
    task automatic pulse(input logic [2:0] c);
        @(posedge clock);
        {rx_done_clr, tx_done_clr, fe_clr} <= c;
        @(posedge clock);
        {rx_done_clr, tx_done_clr, fe_clr} <= 3'h0;
        #1;
    endtask

    task automatic cfg(input logic [1:0] md, input logic mpe, input logic fed);
        @(posedge clock);
        mode             <= md;
        multiproc_enable <= mpe;
        fe_detect_enable <= fed;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] k);
        @(posedge clock);
        {addr_wr, addr_wdata, mask_wr, mask_wdata} <= {1'b1, a, 1'b1, k};
        @(posedge clock);
        {addr_wr, mask_wr} <= 2'h0;
        #1;
        check(slave_individual_addr, a, "addr readback");
        check(slave_addr_mask, k, "mask readback");
    endtask

    // hands one frame to the model; a buffer that never frees ends the run
    task automatic bits(input logic [7:0] d, input logic n);
        logic stuck;
        m.send_bits({d, n}, stuck);
        if (stuck) begin
            check(1'b0, 1'b1, "buffer never ready");
            report_and_stop();
        end
    endtask

    // one frame; acc says whether it should pass, en the expected ninth flag
    task automatic frame(input logic [7:0] d, input logic n, input logic s, input logic acc, input logic en);
        if (acc) q.push_back(d);
        bits(d, n);
        m.send_stop(s);
        #1;
        check(rx_done_flag, acc, "rx done");
        check(rx_ninth_bit, en, "ninth flag");
        pulse(3'h4);
    endtask

    // counts cycles to the next baud tick; bounded so a dead divider ends the run
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (baud_tick !== 1'b1 && n < 200);
        if (n >= 200) begin
            check(1'b0, 1'b1, "no baud tick");
            report_and_stop();
        end
    endtask

    // first two gaps skipped: a rate change only lands at the next reload
    task automatic baud(input logic dcm, input logic bs);
        int   n;
        logic t;
        @(posedge clock);
        double_clock_mode <= dcm;
        baud_double_sel   <= bs;
        repeat (3) wait_tick(n);
        check(n[7:0], (dcm ? 8'h01 : 8'h02) * (bs ? 8'h10 : 8'h20), "baud gap");
        // peripheral tick: steady high when doubled, toggling otherwise
        t = periph_tick;
        @(posedge clock);
        #1;
        check(8'(t) + 8'(periph_tick), dcm ? 8'h02 : 8'h01, "periph tick");
    endtask

    // every byte leaving the buffer must be the next accepted one
    always @(posedge clock) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (q.size() == 0) check(8'h01, 8'h00, "extra byte");
            else check(rx_data, q.pop_front(), "rx byte");
        end
    end

    initial begin
        {rst_n, mode, multiproc_enable, fe_detect_enable, baud_double_sel, double_clock_mode} = '0;
        {serial_irq_enable, global_irq_enable, addr_wr, mask_wr, tx_done_evt} = '0;
        {rx_done_clr, tx_done_clr, fe_clr, addr_wdata, mask_wdata} = '0;
        rx_ready = 1'b1;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check(slave_individual_addr, 8'h00, "addr reset");
        check(slave_addr_mask, 8'h00, "mask reset");
        check(frm_ready, 1'b1, "room after reset");
        cfg(MODE2, 1'b1, 1'b0);
        frame(8'h3C, 1'b1, 1'b1, 1'b1, 1'b1);
        frame(8'h3C, 1'b0, 1'b1, 1'b0, 1'b1);
        wr(8'h56, 8'hFC);
        frame(8'h46, 1'b1, 1'b1, 1'b0, 1'b1);
        frame(8'h57, 1'b1, 1'b1, 1'b1, 1'b1);
        frame(8'hFF, 1'b1, 1'b1, 1'b1, 1'b1);
        cfg(MODE3, 1'b1, 1'b0);
        wr(8'h56, 8'hFF);
        frame(8'h57, 1'b1, 1'b1, 1'b0, 1'b1);
        frame(8'h56, 1'b1, 1'b1, 1'b1, 1'b1);
        cfg(MODE3, 1'b0, 1'b0);
        frame(8'hA5, 1'b0, 1'b1, 1'b1, 1'b0);
        cfg(MODE1, 1'b1, 1'b0);
        frame(8'h56, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(8'h56, 1'b0, 1'b1, 1'b1, 1'b1);
        cfg(MODE0, 1'b1, 1'b0);
        frame(8'h11, 1'b0, 1'b1, 1'b1, 1'b1);
        // framing detection holds the done flag back to the stop bit
        cfg(MODE2, 1'b0, 1'b1);
        q.push_back(8'h22);
        bits(8'h22, 1'b1);
        #1;
        check(rx_done_flag, 1'b0, "done before stop");
        m.send_stop(1'b0);
        #1;
        check(rx_done_flag, 1'b1, "done at stop");
        check(framing_error_flag, 1'b1, "framing set");
        pulse(3'h4);
        frame(8'h33, 1'b1, 1'b1, 1'b1, 1'b1);
        check(framing_error_flag, 1'b1, "framing sticky");
        pulse(3'h1);
        check(framing_error_flag, 1'b0, "framing cleared");
        // shared request from transmit done, gated by both enables
        cfg(MODE2, 1'b0, 1'b0);
        {serial_irq_enable, global_irq_enable, tx_done_evt} <= 3'h7;
        @(posedge clock);
        tx_done_evt <= 1'b0;
        repeat (20) @(posedge clock);
        #1;
        check(tx_done_flag, 1'b1, "tx done held");
        check(serial_irq, 1'b1, "irq on");
        @(posedge clock);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check(serial_irq, 1'b0, "irq gated");
        @(posedge clock);
        {serial_irq_enable, global_irq_enable} <= 2'h1;
        repeat (2) @(posedge clock);
        #1;
        check(serial_irq, 1'b0, "irq gated by serial enable");
        pulse(3'h2);
        check(tx_done_flag, 1'b0, "tx cleared");
        // receive done drives the same request line
        @(posedge clock);
        serial_irq_enable <= 1'b1;
        q.push_back(8'h44);
        bits(8'h44, 1'b1);
        m.send_stop(1'b1);
        #1;
        check(serial_irq, 1'b1, "irq from rx done");
        pulse(3'h4);
        check(serial_irq, 1'b0, "irq follows clear");
        for (int i = 0; i < 4; i++) baud(i[1], i[0]);
        // fill the buffer with the reader stalled, then drain it
        @(posedge clock);
        rx_ready <= 1'b0;
        for (int i = 0; i < 8; i++) frame(8'hC0 + i[7:0], 1'b0, 1'b1, 1'b1, 1'b0);
        check(frm_ready, 1'b0, "buffer refuses");
        @(posedge clock);
        rx_ready <= 1'b1;
        repeat (20) @(posedge clock);
        #1;
        check(rx_valid, 1'b0, "buffer empty");
        check(8'(q.size()), 8'h00, "bytes missing");
        report_and_stop();
    end
endmodule

`default_nettype wire
